/* logic/sbcs_shifter.sv */
`timescale 1ns/100ps
module sbcs_shifter (
  input  wire logic                           mclk,
  input  wire logic                           nrst,
  input  wire logic                           ce,
  input  wire logic                           cs_fall,
  input  wire logic                           sclk_rise,
  input  wire logic                           sclk_fall,
  input  wire logic                           mosi,
  input  wire logic [sbcs_pkg::BYTE_W-1:0]    tx_byte,
  output logic      [sbcs_pkg::BYTE_W-1:0]    rx_byte,
  output logic      [sbcs_pkg::CNT_W-1:0]     bit_cnt,
  output logic                                miso_bit
);
  logic [sbcs_pkg::BYTE_W-1:0] tx_r;

  // =====================================================
  // msb first shift: sample on rising, drive on falling
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rx_byte  <= '0;
      tx_r     <= '0;
      bit_cnt  <= '0;
      miso_bit <= 1'b0;
    end else if (ce) begin
      if (cs_fall) begin
        tx_r     <= {tx_byte[sbcs_pkg::BYTE_W-2:0], 1'b0};
        miso_bit <= tx_byte[sbcs_pkg::BYTE_W-1];
        bit_cnt  <= '0;
      end else begin
        if (sclk_rise) begin
          rx_byte <= {rx_byte[sbcs_pkg::BYTE_W-2:0], mosi};
          // saturate so long frames never alias to eight
          if (bit_cnt != 4'hF)
            bit_cnt <= bit_cnt + 4'h1;
        end
        if (sclk_fall) begin
          miso_bit <= tx_r[sbcs_pkg::BYTE_W-1];
          tx_r     <= {tx_r[sbcs_pkg::BYTE_W-2:0], 1'b0};
        end
      end
    end
  end
endmodule // sbcs_shifter

/* logic/sbcs_spi_control_status.sv */
`timescale 1ns/100ps
module sbcs_spi_control_status (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic                   por_n,
  input  wire sbcs_pkg::sbcs_spi_in_t spi_in,
  input  wire logic                   pwm_in,
  input  wire sbcs_pkg::sbcs_flags_t  flags_in,
  output logic                        miso,
  output logic [1:0]                  slew_select,
  output logic                        bus_pullup_on,
  output logic [2:0]                  switch_on,
  output logic                        sleep_mode,
  output logic                        stop_mode,
  output logic                        watchdog_clear,
  output logic                        wakeup_event,
  output logic                        interrupt_req
);
  // =====================================================
  // pin synchronisation
  logic [2:0] spi_s;
  logic       pwm_s;
  logic       sclk_d_r;
  logic       cs_d_r;
  logic [8:0] flags_s;

  sbcs_sync #(.W(3)) u_spi_sync (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    // select carried active high so the cleared pipe reads as deselected
    .d    ({spi_in.sclk, ~spi_in.cs_n, spi_in.mosi}),
    .q    (spi_s)
  );

  sbcs_sync #(.W(10)) u_flag_sync (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .d    ({pwm_in, flags_in}),
    .q    ({pwm_s, flags_s})
  );

  wire       sclk_s    = spi_s[2];
  wire       cs_s      = ~spi_s[1];
  wire       mosi_s    = spi_s[0];
  wire       cs_fall   = cs_d_r & ~cs_s;
  wire       cs_rise   = ~cs_d_r & cs_s;
  wire       sclk_rise = ~sclk_d_r & sclk_s & ~cs_s;
  wire       sclk_fall = sclk_d_r & ~sclk_s & ~cs_s;
  wire sbcs_pkg::sbcs_flags_t fl = flags_s;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end else if (ce) begin
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_s;
    end
  end

  // =====================================================
  // control register
  logic [1:0] slew_r;
  logic       pullup_r;
  logic [2:0] sw_r;
  logic [1:0] mode_r;
  logic       lp_armed_r;
  logic       sleep_r;
  logic       stop_r;
  logic       wdc_r;

  logic [7:0] rx_byte;
  logic [3:0] bit_cnt;
  wire       frame_ok  = cs_rise & (bit_cnt == 4'h8);
  wire [1:0] wr_slew   = rx_byte[sbcs_pkg::CTL_SLEW_HI:sbcs_pkg::CTL_SLEW_LO];
  wire       wr_pull   = rx_byte[sbcs_pkg::CTL_PULLUP];
  wire [2:0] wr_sw     = rx_byte[sbcs_pkg::CTL_SW3:sbcs_pkg::CTL_SW1];
  wire [1:0] wr_mode   = rx_byte[sbcs_pkg::CTL_MODE_HI:sbcs_pkg::CTL_MODE_LO];
  wire       wr_lp_req = (wr_slew == sbcs_pkg::SBCS_SLEW_LOWPWR);
  wire       wr_lp_cmd = ((rx_byte & sbcs_pkg::LOWPWR_MASK) == sbcs_pkg::LOWPWR_VAL)
                         && !wr_mode[1];
  wire       low_power = sleep_r | stop_r;
  wire       therm_trip = fl.switch_over_temp & ~low_power;
  wire       heat_warn  = fl.regulator_heat_prewarning & ~low_power;

  // power-on resets every control register; device reset spares the pullup bit
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      pullup_r <= sbcs_pkg::PULLUP_RST;
    end else if (ce && frame_ok) begin
      pullup_r <= wr_pull;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst || !por_n) begin
      slew_r     <= sbcs_pkg::SLEW_RST;
      sw_r       <= sbcs_pkg::SW_RST;
      mode_r     <= sbcs_pkg::MODE_RST;
      lp_armed_r <= 1'b0;
      sleep_r    <= 1'b0;
      stop_r     <= 1'b0;
      wdc_r      <= 1'b0;
    end else if (ce) begin
      wdc_r <= 1'b0;
      if (therm_trip)
        sw_r <= '0;
      if (cs_rise && low_power) begin
        sleep_r <= 1'b0;
        stop_r  <= 1'b0;
      end
      if (frame_ok) begin
        if (!wr_lp_req)
          slew_r <= wr_slew;
        if (!therm_trip)
          sw_r <= wr_sw;
        lp_armed_r <= wr_lp_cmd;
        if (wr_lp_cmd && lp_armed_r) begin
          sleep_r <= (wr_mode == sbcs_pkg::SBCS_MODE_SLEEP);
          stop_r  <= (wr_mode == sbcs_pkg::SBCS_MODE_STOP);
        end
        if (wr_mode == sbcs_pkg::SBCS_MODE_NORMWD) begin
          mode_r <= sbcs_pkg::SBCS_MODE_NORMAL;
          wdc_r  <= 1'b1;
        end else begin
          mode_r <= wr_mode;
        end
      end
    end
  end

  // =====================================================
  // event capture and status byte
  logic       irq_r;
  logic       bus_ev_r;
  logic [1:0] wake_src_r;
  logic [1:0] wake_d_r;
  logic       bat_first_r;
  logic       heat_d_r;
  logic       therm_d_r;

  wire [1:0] wake_lvl  = {fl.wake_input_two, fl.wake_input_one};
  wire [1:0] wake_chg  = (wake_lvl ^ wake_d_r) & {2{low_power}};
  wire       bus_ev    = fl.bus_wakeup_flag | fl.bus_fault_flag;
  wire       new_irq   = |wake_chg | (bus_ev & ~bus_ev_r) | (heat_warn & ~heat_d_r)
                         | (therm_trip & ~therm_d_r) | (cs_rise & low_power);
  wire       uv_bit    = bat_first_r ? fl.battery_fail_flag
                                     : fl.supply_undervoltage_flag;
  wire [7:0] status_nxt = {irq_r,
                           bus_ev | bus_ev_r,
                           fl.supply_overvoltage,
                           uv_bit,
                           heat_warn,
                           therm_trip,
                           wake_lvl | wake_src_r};

  // shifter loads the live view at the select fall, so the byte is not a frame stale
  sbcs_shifter u_shift (
    .mclk      (mclk),
    .nrst      (nrst),
    .ce        (ce),
    .cs_fall   (cs_fall),
    .sclk_rise (sclk_rise),
    .sclk_fall (sclk_fall),
    .mosi      (mosi_s),
    .tx_byte   (status_nxt),
    .rx_byte   (rx_byte),
    .bit_cnt   (bit_cnt),
    .miso_bit  (miso)
  );

  always_ff @(posedge mclk) begin
    if (!nrst || !por_n) begin
      irq_r       <= 1'b0;
      bus_ev_r    <= 1'b0;
      wake_src_r  <= 2'h0;
      wake_d_r    <= 2'h0;
      bat_first_r <= 1'b1;
      heat_d_r    <= 1'b0;
      therm_d_r   <= 1'b0;
    end else if (ce) begin
      wake_d_r  <= wake_lvl;
      heat_d_r  <= heat_warn;
      therm_d_r <= therm_trip;
      if (cs_fall) begin
        // latch then clear; a same-cycle event survives
        bat_first_r <= 1'b0;
        irq_r       <= new_irq;
        bus_ev_r    <= bus_ev;
        wake_src_r  <= wake_chg;
      end else begin
        irq_r      <= irq_r | new_irq;
        bus_ev_r   <= bus_ev_r | bus_ev;
        wake_src_r <= wake_src_r | wake_chg;
      end
    end
  end

  // =====================================================
  // outputs
  assign slew_select    = slew_r;
  assign bus_pullup_on  = low_power & ~pullup_r;
  assign switch_on      = (low_power | therm_trip) ? 3'h0
                          : {sw_r[2], sw_r[1:0] & {2{pwm_s}}};
  assign sleep_mode     = sleep_r;
  assign stop_mode      = stop_r;
  assign watchdog_clear = wdc_r;
  assign wakeup_event   = new_irq & low_power;
  assign interrupt_req  = irq_r;

endmodule // sbcs_spi_control_status

/* logic/sbcs_sync.sv */
`timescale 1ns/100ps
module sbcs_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // =====================================================
  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // zero is the idle level of every pin fed in, so no false edge after reset
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sbcs_sync

/* shared/sbcs_pkg.sv */
package sbcs_pkg;

  // =====================================================
  // frame layout
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CNT_W  = 4;

  // =====================================================
  // control byte field positions
  localparam int unsigned CTL_SLEW_HI = 7;
  localparam int unsigned CTL_SLEW_LO = 6;
  localparam int unsigned CTL_PULLUP  = 5;
  localparam int unsigned CTL_SW3     = 4;
  localparam int unsigned CTL_SW2     = 3;
  localparam int unsigned CTL_SW1     = 2;
  localparam int unsigned CTL_MODE_HI = 1;
  localparam int unsigned CTL_MODE_LO = 0;

  // =====================================================
  // status byte field positions
  localparam int unsigned STA_INTERRUPT_SOURCE_FLAG  = 7;
  localparam int unsigned STA_BUS     = 6;
  localparam int unsigned STA_OV      = 5;
  localparam int unsigned STA_UV      = 4;
  localparam int unsigned STA_HEAT    = 3;
  localparam int unsigned STA_THERM   = 2;
  localparam int unsigned STA_WAKE2   = 1;
  localparam int unsigned STA_WAKE1   = 0;

  // =====================================================
  // reset values and low-power command match
  localparam logic [1:0] SLEW_RST   = 2'h0;
  localparam logic       PULLUP_RST = 1'b0;
  localparam logic [2:0] SW_RST     = 3'h0;
  localparam logic [1:0] MODE_RST   = 2'h3;
  localparam logic [7:0] LOWPWR_MASK = 8'hDC;
  localparam logic [7:0] LOWPWR_VAL  = 8'hC0;

  // =====================================================
  // timing
  localparam int unsigned CLK_MHZ     = 50;
  localparam int unsigned CS_GAP_US   = 15;
  localparam int unsigned CS_GAP_CYC  = CS_GAP_US * CLK_MHZ;

  // =====================================================
  // encodings
  typedef enum logic [1:0] {
    SBCS_SLEW_NORMAL = 2'b00,
    SBCS_SLEW_SLOW   = 2'b01,
    SBCS_SLEW_FAST   = 2'b10,
    SBCS_SLEW_LOWPWR = 2'b11
  } sbcs_slew_t;

  typedef enum logic [1:0] {
    SBCS_MODE_SLEEP  = 2'b00,
    SBCS_MODE_STOP   = 2'b01,
    SBCS_MODE_NORMWD = 2'b10,
    SBCS_MODE_NORMAL = 2'b11
  } sbcs_mode_t;

  typedef struct packed {
    logic       bus_wakeup_flag;
    logic       bus_fault_flag;
    logic       supply_overvoltage;
    logic       supply_undervoltage_flag;
    logic       battery_fail_flag;
    logic       regulator_heat_prewarning;
    logic       switch_over_temp;
    logic       wake_input_two;
    logic       wake_input_one;
  } sbcs_flags_t;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       mosi;
  } sbcs_spi_in_t;

endpackage

/* tb/sbcs_checker.sv */
`timescale 1ns/100ps
module sbcs_checker (
  input wire logic                   mclk,
  input wire logic                   nrst,
  input wire logic                   ce,
  input wire logic                   por_n,
  input wire sbcs_pkg::sbcs_spi_in_t spi_in,
  input wire logic                   pwm_in,
  input wire sbcs_pkg::sbcs_flags_t  flags_in,
  input wire logic                   miso,
  input wire logic [1:0]             slew_select,
  input wire logic                   bus_pullup_on,
  input wire logic [2:0]             switch_on,
  input wire logic                   sleep_mode,
  input wire logic                   stop_mode,
  input wire logic                   watchdog_clear,
  input wire logic                   wakeup_event,
  input wire logic                   interrupt_req
);
  // ================
  // steps
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst || !por_n);
  sequence lp_rise;
    $rose(sleep_mode || stop_mode);
  endsequence
  sequence cs_end_in_stop;
    stop_mode ##0 $rose(spi_in.cs_n);
  endsequence
  sequence wake_then_normal;
    ##[1:8] wakeup_event ##[0:8] !stop_mode;
  endsequence
  // ================
  // assertions
  lp_entry_a: assert property (lp_rise |-> $stable(slew_select) && spi_in.cs_n)
    else $error("low power entry moved slew or came mid frame");
  mode_excl_a: assert property (!(sleep_mode && stop_mode))
    else $error("sleep and stop both set");
  pullup_lp_a: assert property (bus_pullup_on |-> sleep_mode || stop_mode)
    else $error("pullup connected in normal mode");
  lp_sw_off_a: assert property ((sleep_mode || stop_mode) |-> switch_on == 3'h0)
    else $error("switch on in low power");
  wd_pulse_a: assert property (watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear longer than one cycle");
  wd_normal_a: assert property (watchdog_clear |-> spi_in.cs_n && !sleep_mode && !stop_mode)
    else $error("watchdog clear outside normal mode or frame end");
  slew_frame_a: assert property ($changed(slew_select) && $past(nrst) && $past(por_n)
    |-> spi_in.cs_n)
    else $error("slew changed inside a frame");
  thermal_off_a: assert property (flags_in.switch_over_temp [*6] |-> switch_on == 3'h0)
    else $error("switch on during thermal shutdown");
  stop_wake_a: assert property (cs_end_in_stop |-> wake_then_normal)
    else $error("chip select rise did not wake from stop");
  heat_irq_a: assert property ($rose(flags_in.regulator_heat_prewarning) && !sleep_mode
    && !stop_mode |-> ##[3:8] interrupt_req)
    else $error("prewarning raised no interrupt");
endmodule // sbcs_checker

/* tb/sbcs_spi_master.sv */
`timescale 1ns/100ps
module sbcs_spi_master #(
  parameter int HALF = 80
) (
  output sbcs_pkg::sbcs_spi_in_t spi,
  input  wire logic              miso
);
  initial spi = 3'b010;
  task automatic xfer(input logic [7:0] b, input int nb, output logic [7:0] r);
    // odd offset keeps link edges away from mclk edges
    #7 spi.cs_n = 1'b0;
    #(2 * HALF);
    for (int i = 0; i < nb; i++) begin
      spi.mosi = b[7 - i % 8];
      #HALF r = {r[6:0], miso};
      spi.sclk = 1'b1;
      #HALF spi.sclk = 1'b0;
    end
    #HALF spi.cs_n = 1'b1;
    spi.mosi = ~spi.mosi;
    #15000;
  endtask
endmodule // sbcs_spi_master

/* tb/testbench.sv */
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  $display("mismatch %s exp %h got %h", n, e, a); failures++; end end
module testbench;
  logic                   mclk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   por_n = 1'b0;
  logic                   pwm_in = 1'b0;
  sbcs_pkg::sbcs_flags_t  flags_in = 9'h010;
  sbcs_pkg::sbcs_flags_t  old_f;
  sbcs_pkg::sbcs_flags_t  ev [2] = '{9'h004, 9'h008};
  sbcs_pkg::sbcs_spi_in_t spi_in;
  logic                   miso, bus_pullup_on, sleep_mode, stop_mode;
  logic                   watchdog_clear, wakeup_event, interrupt_req;
  logic [1:0]             slew_select, s;
  logic [2:0]             switch_on;
  logic [7:0]             rx, tx;
  logic [31:0]            seed = 32'h0001278B;
  int                     failures = 0, check_count = 0, wd_seen = 0, wd_exp = 0;
  int                     wk_seen = 0, n;

  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    wd_seen <= wd_seen + int'(watchdog_clear);
    wk_seen <= wk_seen + int'(wakeup_event);
  end

  sbcs_spi_control_status dut (.mclk(mclk), .nrst(nrst), .ce(1'b1), .por_n(por_n),
    .spi_in(spi_in), .pwm_in(pwm_in), .flags_in(flags_in), .miso(miso),
    .slew_select(slew_select), .bus_pullup_on(bus_pullup_on), .switch_on(switch_on),
    .sleep_mode(sleep_mode), .stop_mode(stop_mode), .watchdog_clear(watchdog_clear),
    .wakeup_event(wakeup_event), .interrupt_req(interrupt_req));
  sbcs_spi_master m (.spi(spi_in), .miso(miso));

  // ================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // interrupt view left out: only flag view is predicted here
  function automatic logic [7:0] st(input sbcs_pkg::sbcs_flags_t f, input logic first);
    return {1'b0, f.bus_wakeup_flag | f.bus_fault_flag, f.supply_overvoltage,
      first ? f.battery_fail_flag : f.supply_undervoltage_flag,
      f.regulator_heat_prewarning, f.switch_over_temp, f.wake_input_two, f.wake_input_one};
  endfunction
  task automatic go(input logic [7:0] b, input int nb = 8);
    @(posedge mclk);
    m.xfer(b, nb, rx);
    wd_exp += int'(nb == 8 && b[1:0] == 2'b10);
  endtask
  task end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 50) begin
      failures++;
      end_sim();
    end
  endtask

  // ================
  // sequence
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("reset", 8'h00, {slew_select, switch_on, sleep_mode, stop_mode, interrupt_req})
    go(8'h03);
    `CHK("first read", st(flags_in, 1'b1), rx)
    for (int k = 0; k < 10; k++) begin
      tx = 8'(xs());
      if (tx[7:6] == 2'b11) tx[7] = 1'b0;
      pwm_in <= seed[20];
      flags_in <= seed[16:8] & 9'h070;
      repeat (6) @(posedge mclk);
      old_f = flags_in;
      fork
        go(tx);
        #400 flags_in <= 9'(xs()) & 9'h070;
      join
      `CHK("status", st(old_f, 1'b0), rx)
      `CHK("slew", tx[7:6], slew_select)
      `CHK("switch", {tx[4], tx[3:2] & {2{pwm_in}}}, switch_on)
      `CHK("mode", 2'b00, {sleep_mode, stop_mode})
    end
    go(8'h43);
    `CHK("slow slew", 2'b01, slew_select)
    s = slew_select;
    go(8'hC3);
    `CHK("slew kept", s, slew_select)
    go(8'h03, 7);
    go(8'h43, 9);
    `CHK("short frame", s, slew_select)
    pwm_in <= 1'b1;
    go(8'h1E);
    `CHK("watchdog", wd_exp, wd_seen)
    `CHK("all on", 3'h7, switch_on)
    for (int k = 0; k < 2; k++) begin
      flags_in <= ev[k];
      for (n = 0; n < 50 && interrupt_req !== 1'b1; n++) @(posedge mclk);
      tmo(n);
      `CHK("tripped", 3'h0, switch_on)
      go(8'h03);
      `CHK("source", {1'b1, ev[k][6:0]}, rx)
    end
    flags_in <= 9'h080;
    repeat (10) @(posedge mclk);
    go(8'h03);
    `CHK("bus flag", 7'h40, rx[6:0])
    go(8'hC1);
    `CHK("one stop", 1'b0, stop_mode)
    go(8'hC1);
    `CHK("stop", 3'b011, {sleep_mode, stop_mode, bus_pullup_on})
    n = wk_seen;
    go(8'h03);
    `CHK("cs wake", 2'b10, {wk_seen > n, stop_mode})
    go(8'hE0);
    go(8'hE0);
    `CHK("sleep", 3'b100, {sleep_mode, stop_mode, bus_pullup_on})
    n = wk_seen;
    flags_in <= 9'h001;
    repeat (10) @(posedge mclk);
    `CHK("pin wake", 1'b1, wk_seen > n)
    flags_in <= 9'h000;
    repeat (10) @(posedge mclk);
    go(8'h03);
    `CHK("wake source", 2'b01, rx[1:0])
    end_sim();
  end
endmodule // testbench

bind sbcs_spi_control_status sbcs_checker u_chk (.mclk(mclk), .nrst(nrst), .ce(ce),
  .por_n(por_n), .spi_in(spi_in), .pwm_in(pwm_in), .flags_in(flags_in), .miso(miso),
  .slew_select(slew_select), .bus_pullup_on(bus_pullup_on), .switch_on(switch_on),
  .sleep_mode(sleep_mode), .stop_mode(stop_mode), .watchdog_clear(watchdog_clear),
  .wakeup_event(wakeup_event), .interrupt_req(interrupt_req));
